// file: common/dri_defines.svh
/*
 * Constants of the dynamic RAM refresh interface: widths, field positions,
 * idle levels and refresh timing.
 * Assumes a 20 MHz reference clock and the processor bus of an 8-bit machine.
 */
`ifndef DRI_DEFINES_SVH
`define DRI_DEFINES_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define DRI_ADDR_W 16
`define DRI_DATA_W 8
`define DRI_MA_W 7
`define DRI_HALF_4K_W 6
`define DRI_HALF_16K_W 7
`define DRI_BANKS 4
`define DRI_BANK_W 2

// ****************************************************************
// Field positions of the bank select bits in the processor address
// ****************************************************************
`define DRI_BANK_LSB_4K 12
`define DRI_BANK_LSB_16K 14

// ****************************************************************
// Idle and reset levels
// ****************************************************************
`define DRI_RAS_IDLE 4'hF
`define DRI_DATA_RESET 8'h00
`define DRI_MA_RESET 7'h00
`define DRI_ADDR_RESET 16'h0000

// ****************************************************************
// Refresh timing: evenly spread refresh interval per organisation
// ****************************************************************
`define DRI_CLK_PERIOD_NS 50
`define DRI_REF_4K_NS 32000
`define DRI_REF_16K_NS 16000
`define DRI_REF_4K_CYC (`DRI_REF_4K_NS / `DRI_CLK_PERIOD_NS)
`define DRI_REF_16K_CYC (`DRI_REF_16K_NS / `DRI_CLK_PERIOD_NS)
`define DRI_REF_CNT_W 10

`endif

// file: common/dri_pkg.sv
/*
 * Types of the dynamic RAM refresh interface.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package dri_pkg;

  // ****************************************************************
  // Memory cycle sequencer states
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ROW,
    ST_RAS,
    ST_COL,
    ST_CAS,
    ST_REF,
    ST_PRE
  } dri_state_e;

endpackage : dri_pkg

// file: hw/dri_addr_mux.sv
/*
 * Row and column address multiplexer for 4K and 16K multiplexed-address RAMs.
 * Assumes the caller registers the output before it reaches the RAM pins.
 */
`timescale 1ns/1ns
`include "dri_defines.svh"

module dri_addr_mux (
  input wire logic [`DRI_ADDR_W-1:0] addr_i,
  input wire logic size_16k_i,
  input wire logic col_sel_i,
  output logic [`DRI_MA_W-1:0] ma_o
);

  // ****************************************************************
  // Half selection
  // ****************************************************************

  // The 4K part uses six bits a half, so the top multiplexed line stays low.
  always_comb begin
    if (size_16k_i) begin
      if (col_sel_i) begin
        ma_o = addr_i[2*`DRI_HALF_16K_W-1:`DRI_HALF_16K_W];
      end else begin
        ma_o = addr_i[`DRI_HALF_16K_W-1:0];
      end
    end else begin
      if (col_sel_i) begin
        ma_o = {1'b0, addr_i[2*`DRI_HALF_4K_W-1:`DRI_HALF_4K_W]};
      end else begin
        ma_o = {1'b0, addr_i[`DRI_HALF_4K_W-1:0]};
      end
    end
  end

endmodule : dri_addr_mux

// file: hw/dri_top.sv
/*
 * Dynamic RAM interface between an 8-bit processor bus and four banks of
 * 16-pin multiplexed-address RAMs, with row-only refresh and refresh watchdog.
 * Assumes the processor bus pins are asynchronous to ref_clk_i and that the
 * processor supplies refresh row numbers on the low address bits.
 */
`timescale 1ns/1ns
`include "dri_defines.svh"

module dri_top (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic memory_request_strobe_n_i,
  input wire logic refresh_indicator_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic size_16k_i,
  input wire logic [`DRI_ADDR_W-1:0] addr_i,
  input wire logic [`DRI_DATA_W-1:0] cpu_data_i,
  input wire logic [`DRI_DATA_W-1:0] ram_data_i,
  output logic [`DRI_MA_W-1:0] ma_o,
  output logic [`DRI_BANKS-1:0] ras_n_o,
  output logic cas_n_o,
  output logic we_n_o,
  output logic [`DRI_DATA_W-1:0] ram_data_o,
  output logic [`DRI_DATA_W-1:0] cpu_data_o,
  output logic cpu_data_oe_o,
  output logic ram_out_valid_o,
  output logic row_refreshed_o,
  output logic refresh_late_o
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int SYNC_W = 5 + `DRI_ADDR_W + 2 * `DRI_DATA_W;

  logic [SYNC_W-1:0] meta_q; // First stage, read only by sync_q.
  logic [SYNC_W-1:0] sync_q; // Second stage, safe for logic.
  logic req_s; // Memory request, active high.
  logic refresh_s; // Refresh indicator, active high.
  logic rd_s; // Read strobe, active high.
  logic wr_s; // Write strobe, active high.
  logic size_s; // Jumper: high selects the 16K organisation.
  logic [`DRI_ADDR_W-1:0] addr_s;
  logic [`DRI_DATA_W-1:0] cpu_data_s;
  logic [`DRI_DATA_W-1:0] ram_data_s;

  // All pins pass two flip-flops; the extra latency is far below a bus cycle.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= '1;
      sync_q <= '1;
    end else begin
      meta_q <= {memory_request_strobe_n_i, refresh_indicator_n_i, rd_n_i, wr_n_i,
                 size_16k_i, addr_i, cpu_data_i, ram_data_i};
      sync_q <= meta_q;
    end
  end

  assign {req_s, refresh_s, rd_s, wr_s} = ~sync_q[SYNC_W-1 -: 4];
  assign {size_s, addr_s, cpu_data_s, ram_data_s} = sync_q[SYNC_W-5:0];

  // ****************************************************************
  // Bank decode
  // ****************************************************************

  // One-hot bank select from the upper address bits of the chosen organisation.
  function automatic logic [`DRI_BANKS-1:0] bank_sel(input logic [`DRI_ADDR_W-1:0] a,
                                                    input logic big);
    logic [`DRI_BANK_W-1:0] b;
    b = big ? a[`DRI_BANK_LSB_16K +: `DRI_BANK_W] : a[`DRI_BANK_LSB_4K +: `DRI_BANK_W];
    bank_sel = `DRI_BANKS'(1) << b;
  endfunction : bank_sel

  // ****************************************************************
  // Cycle sequencer
  // ****************************************************************
  dri_pkg::dri_state_e state_q; // Current sequencer state.
  dri_pkg::dri_state_e state_d; // Next sequencer state.
  logic refresh_q; // Current cycle is a row-only refresh.
  logic size_q; // Organisation held for the whole cycle.
  logic [`DRI_ADDR_W-1:0] addr_q; // Address held while the request stands.
  logic [`DRI_MA_W-1:0] mux_ma; // Multiplexer output.

  // Each step lasts at least one clock so address setup precedes each strobe.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      dri_pkg::ST_IDLE: state_d = req_s ? dri_pkg::ST_ROW : dri_pkg::ST_IDLE;
      dri_pkg::ST_ROW: begin
        // A request that vanished before RAS is dropped harmlessly.
        if (!req_s) begin
          state_d = dri_pkg::ST_PRE;
        end else if (refresh_q) begin
          state_d = dri_pkg::ST_REF;
        end else begin
          state_d = dri_pkg::ST_RAS;
        end
      end
      dri_pkg::ST_RAS: state_d = req_s ? dri_pkg::ST_COL : dri_pkg::ST_PRE;
      dri_pkg::ST_COL: state_d = req_s ? dri_pkg::ST_CAS : dri_pkg::ST_PRE;
      // Strobes stand until the processor lifts its request.
      dri_pkg::ST_CAS, dri_pkg::ST_REF: state_d = req_s ? state_q : dri_pkg::ST_PRE;
      dri_pkg::ST_PRE: state_d = dri_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= dri_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Address, organisation and cycle kind are captured once at the request.
  // Holding the bank bits keeps the RAS decode free of glitches.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      addr_q <= `DRI_ADDR_RESET;
      size_q <= 1'b0;
      refresh_q <= 1'b0;
    end else if (state_q == dri_pkg::ST_IDLE && req_s) begin
      addr_q <= addr_s;
      size_q <= size_s;
      refresh_q <= refresh_s;
    end
  end

  // While idle the pins feed the mux, so the row half loads at the capture edge.
  dri_addr_mux i_dri_addr_mux (
    .addr_i(state_q == dri_pkg::ST_IDLE ? addr_s : addr_q),
    .size_16k_i(state_q == dri_pkg::ST_IDLE ? size_s : size_q),
    .col_sel_i(state_d == dri_pkg::ST_COL),
    .ma_o(mux_ma)
  );

  // ****************************************************************
  // RAM strobes and address
  // ****************************************************************

  // Row half is loaded at ROW, column half at COL, each a clock before its strobe.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ma_o <= `DRI_MA_RESET;
    end else if (state_d == dri_pkg::ST_ROW || state_d == dri_pkg::ST_COL) begin
      ma_o <= mux_ma;
    end
  end

  // Refresh drops RAS on every bank and never CAS; access drops one bank.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ras_n_o <= `DRI_RAS_IDLE;
      cas_n_o <= 1'b1;
      we_n_o <= 1'b1;
    end else begin
      unique case (state_d)
        dri_pkg::ST_REF: ras_n_o <= '0;
        dri_pkg::ST_RAS, dri_pkg::ST_COL, dri_pkg::ST_CAS: begin
          ras_n_o <= ~bank_sel(addr_q, size_q);
        end
        default: ras_n_o <= `DRI_RAS_IDLE;
      endcase
      cas_n_o <= !(state_d == dri_pkg::ST_CAS);
      we_n_o <= !(wr_s && (state_d == dri_pkg::ST_COL || state_d == dri_pkg::ST_CAS));
    end
  end

  // A pulse marks each RAS fall: the addressed row has then been restored.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      row_refreshed_o <= 1'b0;
    end else begin
      row_refreshed_o <= state_q == dri_pkg::ST_ROW &&
                         (state_d == dri_pkg::ST_RAS || state_d == dri_pkg::ST_REF);
    end
  end

  // ****************************************************************
  // Data paths
  // ****************************************************************

  // Read data reaches the processor only while its read strobe stands.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cpu_data_o <= `DRI_DATA_RESET;
      cpu_data_oe_o <= 1'b0;
      ram_data_o <= `DRI_DATA_RESET;
    end else begin
      cpu_data_o <= ram_data_s;
      cpu_data_oe_o <= rd_s && state_d == dri_pkg::ST_CAS;
      ram_data_o <= cpu_data_s;
    end
  end

  // RAM output state: a read turns it on; a refresh clears it on 16K parts
  // and leaves the previous state on 4K parts.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ram_out_valid_o <= 1'b0;
    end else if (state_d == dri_pkg::ST_REF && size_q) begin
      ram_out_valid_o <= 1'b0;
    end else if (state_d == dri_pkg::ST_CAS) begin
      ram_out_valid_o <= rd_s;
    end
  end

  // ****************************************************************
  // Refresh watchdog
  // ****************************************************************
  logic [`DRI_REF_CNT_W-1:0] ref_cnt_q; // Clocks since the last refresh.
  logic [`DRI_REF_CNT_W-1:0] ref_lim; // Interval of the jumpered size.
  logic ref_seen; // A refresh RAS starts this clock.

  assign ref_lim = size_s ? `DRI_REF_CNT_W'(`DRI_REF_16K_CYC) : `DRI_REF_CNT_W'(`DRI_REF_4K_CYC);
  assign ref_seen = state_q == dri_pkg::ST_ROW && state_d == dri_pkg::ST_REF;

  // The processor owns the refresh pace; this only flags a late refresh.
  // A refresh arriving in the clock the limit is hit still clears the flag.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_cnt_q <= '0;
      refresh_late_o <= 1'b0;
    end else if (ref_seen) begin
      ref_cnt_q <= '0;
      refresh_late_o <= 1'b0;
    end else if (ref_cnt_q >= ref_lim) begin
      refresh_late_o <= 1'b1;
    end else begin
      ref_cnt_q <= ref_cnt_q + `DRI_REF_CNT_W'(1);
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // All checks run on the one reference clock and sleep during reset.
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_row_setup;
    ($past(ras_n_o) == `DRI_RAS_IDLE && ras_n_o != `DRI_RAS_IDLE) |-> $stable(ma_o);
  endproperty
  a_row_setup: assert property (p_row_setup) else $error("Row address moved at RAS.");
  property p_cas_after_ras;
    $fell(cas_n_o) |-> ras_n_o != `DRI_RAS_IDLE && $past(ras_n_o, 2) != `DRI_RAS_IDLE;
  endproperty
  a_cas_after_ras: assert property (p_cas_after_ras) else $error("CAS fell early.");
  property p_ref_ras_only;
    state_q == dri_pkg::ST_REF |-> ras_n_o == '0 && cas_n_o;
  endproperty
  a_ref_ras_only: assert property (p_ref_ras_only) else $error("Refresh not RAS only.");
  property p_read_only_oe;
    cpu_data_oe_o |-> $past(rd_s) && !cas_n_o;
  endproperty
  a_read_only_oe: assert property (p_read_only_oe) else $error("Data driven off read.");
  property p_bank_hold;
    state_q inside {dri_pkg::ST_COL, dri_pkg::ST_CAS} |-> $stable(addr_q) && $stable(ras_n_o);
  endproperty
  a_bank_hold: assert property (p_bank_hold) else $error("Bank decode moved in cycle.");
  property p_4k_split;
    (!size_q && state_q != dri_pkg::ST_IDLE && state_q != dri_pkg::ST_PRE) |-> !ma_o[`DRI_MA_W-1];
  endproperty
  a_4k_split: assert property (p_4k_split) else $error("Top line driven in 4K mode.");
  property p_16k_out_off;
    (state_q == dri_pkg::ST_REF && size_q) |-> !ram_out_valid_o;
  endproperty
  a_16k_out_off: assert property (p_16k_out_off) else $error("16K output left on.");
  property p_row_pulse;
    ($past(ras_n_o) == `DRI_RAS_IDLE && ras_n_o != `DRI_RAS_IDLE) |-> row_refreshed_o;
  endproperty
  a_row_pulse: assert property (p_row_pulse) else $error("No row pulse at RAS fall.");
  property p_late;
    (ref_cnt_q >= ref_lim && !ref_seen) |=> refresh_late_o;
  endproperty
  a_late: assert property (p_late) else $error("Late refresh not flagged.");

endmodule : dri_top

// file: bench/dri_cpu_model.sv
/*
 * Processor bus model: issues memory reads, writes and refresh cycles to the
 * dynamic RAM interface and owns the refresh row counter.
 * Assumes the caller enters its task between clock edges, after a falling edge.
 */
`timescale 1ns/1ns
`include "dri_defines.svh"

module dri_cpu_model (
  input wire logic clk_i,
  input wire logic size_16k_i,
  output logic memory_request_strobe_n_o,
  output logic refresh_indicator_n_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [`DRI_ADDR_W-1:0] addr_o,
  output logic [`DRI_DATA_W-1:0] data_o
);
  // ****************************************************************
  // Bus state
  // ****************************************************************
  // Next row to refresh; the processor keeps it, the interface only uses it.
  logic [6:0] refresh_row = 7'h00;

  // All strobes idle from time zero so no cycle starts before reset ends.
  initial begin
    memory_request_strobe_n_o = 1'b1;
    refresh_indicator_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    addr_o = 16'h0000;
    data_o = 8'h00;
  end

  // One bus cycle: kind 0 read, 1 write, 2 refresh; hold counts clocks of request.
  task automatic cycle(input int kind, input logic [15:0] a, input logic [7:0] d,
                       input int hold);
    @(negedge clk_i);
    addr_o = (kind == 2) ? {a[15:7], refresh_row} : a;
    data_o = d;
    rd_n_o = (kind != 0);
    wr_n_o = (kind != 1);
    refresh_indicator_n_o = (kind != 2);
    memory_request_strobe_n_o = 1'b0;
    // Address and data stay put while the request is low.
    repeat (hold) @(negedge clk_i);
    memory_request_strobe_n_o = 1'b1;
    refresh_indicator_n_o = 1'b1;
    rd_n_o = 1'b1;
    wr_n_o = 1'b1;
    // A released bus must not keep showing the old value, or stale latches pass.
    addr_o = ~addr_o;
    data_o = ~data_o;
    if (kind == 2) begin
      refresh_row = (refresh_row + 7'h01) & (size_16k_i ? 7'h7F : 7'h3F);
    end
  endtask : cycle
endmodule : dri_cpu_model

// file: bench/dri_top_tb.sv
/*
 * Self-checking bench of the dynamic RAM interface: random accesses and
 * refreshes in both organisations, an abandoned cycle and the refresh watchdog.
 * Assumes the processor model and the design files are compiled first.
 */
`timescale 1ns/1ns
`include "dri_defines.svh"

module dri_top_tb;
  // Expected memory cycle, queued by the driver and consumed by the monitor.
  typedef struct {
    logic [6:0] row;
    logic [6:0] col;
    logic [3:0] ras;
    int kind;
    logic [7:0] dat;
    logic vld;
  } dri_note_s;

  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic size_16k_i = 1'b0;
  logic [7:0] ram_data_i = 8'h00;
  logic req_n, rfi_n, rd_n, wr_n;
  logic [15:0] addr;
  logic [7:0] cpu_data;
  logic [6:0] ma_o;
  logic [3:0] ras_n_o;
  logic cas_n_o, we_n_o, cpu_data_oe_o, ram_out_valid_o, row_refreshed_o, refresh_late_o;
  logic [7:0] ram_data_o, cpu_data_o;
  logic exp_vld = 1'b0; // Modelled RAM output state.
  dri_note_s notes[$];
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;

  dri_cpu_model i_dri_cpu_model (.clk_i(ref_clk_i), .size_16k_i(size_16k_i),
    .memory_request_strobe_n_o(req_n), .refresh_indicator_n_o(rfi_n), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .addr_o(addr), .data_o(cpu_data));

  dri_top i_dri_top (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .memory_request_strobe_n_i(req_n), .refresh_indicator_n_i(rfi_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .size_16k_i(size_16k_i), .addr_i(addr), .cpu_data_i(cpu_data),
    .ram_data_i(ram_data_i), .ma_o(ma_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o),
    .we_n_o(we_n_o), .ram_data_o(ram_data_o), .cpu_data_o(cpu_data_o),
    .cpu_data_oe_o(cpu_data_oe_o), .ram_out_valid_o(ram_out_valid_o),
    .row_refreshed_o(row_refreshed_o), .refresh_late_o(refresh_late_o));

  // ****************************************************************
  // Clock, timeout and reporting
  // ****************************************************************
  // A 50 ns clock.
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // The whole run needs about 1320 clocks; a hang is cut off well after that.
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      results();
    end
  end

  task automatic results;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // ****************************************************************
  // Driver
  // ****************************************************************
  // Works out the strobes and address halves that a cycle must produce.
  function automatic dri_note_s note_of(int kind, logic [15:0] a, logic [7:0] d, logic big,
                                        logic [6:0] rr, logic v);
    dri_note_s n;
    n.kind = kind;
    n.dat = d;
    n.vld = v;
    n.row = (kind == 2) ? rr : (big ? a[6:0] : {1'b0, a[5:0]});
    n.col = big ? a[13:7] : {1'b0, a[11:6]};
    n.ras = (kind == 2) ? 4'h0 : ~(4'h1 << (big ? a[15:14] : a[13:12]));
    return n;
  endfunction : note_of

  // Runs one cycle; a hold of one clock is dropped before the row strobe.
  task automatic op(input int kind, input int hold);
    logic [15:0] a;
    logic [7:0] d;
    @(negedge ref_clk_i);
    a = 16'($urandom);
    d = 8'($urandom);
    ram_data_i = 8'($urandom);
    // The row strobe falls from a hold of two clocks on, the column strobe from four.
    // Only a cycle that reaches the column strobe, or a 16K refresh, changes the RAM output state.
    if (hold > 1) begin
      if (hold > 3 && kind != 2) exp_vld = (kind == 0);
      if (kind == 2 && size_16k_i) exp_vld = 1'b0;
      notes.push_back(note_of(kind, a, (kind == 0) ? ram_data_i : d, size_16k_i,
                              i_dri_cpu_model.refresh_row, exp_vld));
    end
    i_dri_cpu_model.cycle(kind, a, d, hold);
    repeat (4) @(negedge ref_clk_i);
  endtask : op

  // ****************************************************************
  // Monitor
  // ****************************************************************
  // Pairs every row strobe with the oldest queued note and checks the cycle.
  initial begin : monitor
    dri_note_s n;
    logic [3:0] ras_prev;
    logic cas_prev;
    logic cas_seen;
    ras_prev = 4'hF;
    cas_prev = 1'b1;
    cas_seen = 1'b0;
    forever begin
      @(negedge ref_clk_i);
      if (ras_n_o !== 4'hF && ras_prev === 4'hF) begin
        cas_seen = 1'b0;
        if (notes.size() == 0) begin
          check(16'(ras_n_o), 16'hF);
        end else begin
          n = notes.pop_front();
          check(16'(ras_n_o), 16'(n.ras));
          check(16'(ma_o), 16'(n.row));
          check(16'(row_refreshed_o), 16'h1);
        end
      end
      if (cas_n_o === 1'b0 && cas_prev === 1'b1) begin
        cas_seen = 1'b1;
        check(16'(ma_o), 16'(n.col));
        check(16'(we_n_o), 16'(n.kind != 1));
        check(16'(cpu_data_oe_o), 16'(n.kind == 0));
        check(16'((n.kind == 0) ? cpu_data_o : ram_data_o), 16'(n.dat));
      end
      if (ras_n_o === 4'hF && ras_prev !== 4'hF && n.kind == 2) begin
        check(16'(cas_seen), 16'h0);
        check(16'(ram_out_valid_o), 16'(n.vld));
      end
      ras_prev = ras_n_o;
      cas_prev = cas_n_o;
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Both organisations: mixed traffic, an abandoned cycle, then the watchdog.
  initial begin : main
    int lim;
    void'($urandom(58966));
    repeat (8) @(negedge ref_clk_i);
    sys_rst_i = 1'b0;
    check(16'({ras_n_o, cas_n_o}), 16'h1F);
    for (int s = 0; s < 2; s++) begin
      size_16k_i = s[0];
      lim = s ? `DRI_REF_16K_CYC : `DRI_REF_4K_CYC;
      repeat (4) @(negedge ref_clk_i);
      for (int i = 0; i < 12; i++) begin
        op(i % 3, 3 + i % 5);
      end
      op(0, 1);
      op(2, 8);
      repeat (lim - 40) @(negedge ref_clk_i);
      check(16'(refresh_late_o), 16'h0);
      repeat (50) @(negedge ref_clk_i);
      check(16'(refresh_late_o), 16'h1);
      op(2, 8);
      check(16'(refresh_late_o), 16'h0);
    end
    results();
  end
endmodule : dri_top_tb
